/* core/lvds_map_pkg.sv */
// ****************************************************************
// Register map, field layout and default routing
// ****************************************************************
`default_nettype none
package lvds_map_pkg;

    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 12;
    localparam int          IDX_W         = 8;
    localparam int          REG_W         = 16;

    // Register indices; the byte address is four times the index
    localparam logic [7:0]  MAP_A_IDX     = 8'h53;
    localparam logic [7:0]  MAP_B_IDX     = 8'h54;
    localparam logic [7:0]  MAP_C_IDX     = 8'h55;
    localparam logic [7:0]  COEFF_LAST_IDX = 8'hA1;

    localparam int          CH_COUNT      = 6;
    localparam int          TAPS_PER_CH   = 12;
    localparam int          TAP_COUNT     = 72;
    localparam int          TAP_AW        = 7;
    localparam int          COEFF_W       = 12;
    localparam int          SEL_W         = 4;

    // First register of each channel's coefficient bank
    localparam logic [7:0]  COEFF_BASE [CH_COUNT] = '{
        8'h5A, 8'h66, 8'h72, 8'h7E, 8'h8A, 8'h96
    };

    // Field positions inside a 16-bit register
    localparam int          EN_BIT        = 15;
    localparam int          SEL_HI_LSB    = 8;
    localparam int          SEL_MID_LSB   = 4;
    localparam int          SEL_LO_LSB    = 0;

    // Writable bits, then the mapping reset value; everything else reads as zero
    localparam logic [15:0] MAP_AB_MASK   = 16'h8FFF;
    localparam logic [15:0] MAP_C_MASK    = 16'h80FF;
    localparam logic [15:0] COEFF_MASK    = 16'h8FFF;
    localparam logic [15:0] MAP_RST       = 16'h0000;

    // Routing used while a mapping register is disabled
    localparam logic [3:0]  DEF_SEL_5A    = 4'h0;
    localparam logic [3:0]  DEF_SEL_5B    = 4'h1;
    localparam logic [3:0]  DEF_SEL_6A    = 4'h2;
    localparam logic [3:0]  DEF_SEL_6B    = 4'h3;
    localparam logic [3:0]  DEF_SEL_7A    = 4'h4;
    localparam logic [3:0]  DEF_SEL_7B    = 4'h5;
    localparam logic [3:0]  DEF_SEL_8A    = 4'h6;
    localparam logic [3:0]  DEF_SEL_8B    = 4'h7;

endpackage

`default_nettype wire

/* core/tap_mem.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Coefficient store: one write port, two registered read ports
// ****************************************************************
module tap_mem #(
    parameter int W     = 12,
    parameter int DEPTH = 72,
    parameter int AW    = 7
) (
    input  wire logic          clk_sys,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic [AW-1:0] rd_a_addr,
    output logic      [W-1:0]  rd_a_data,
    input  wire logic [AW-1:0] rd_b_addr,
    output logic      [W-1:0]  rd_b_data
);

    // No reset so the array maps onto RAM; contents are unknown until written
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_a_data <= mem[rd_a_addr];
        rd_b_data <= mem[rd_b_addr];
    end

endmodule

`default_nettype wire

/* core/lvds_map_and_coeff_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module lvds_map_and_coeff_regs
    import lvds_map_pkg::*;
#(
    parameter int CH_N  = CH_COUNT,
    parameter int TAPS  = TAPS_PER_CH
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [2:0]        tap_rd_ch,
    input  wire logic [3:0]        tap_rd_idx,
    output logic      [COEFF_W-1:0] user_tap_value,
    output logic      [CH_N-1:0]   user_taps_select,
    output logic      [SEL_W-1:0]  pair_5a_source_sel,
    output logic      [SEL_W-1:0]  pair_5b_source_sel,
    output logic      [SEL_W-1:0]  pair_6a_source_sel,
    output logic      [SEL_W-1:0]  pair_6b_source_sel,
    output logic      [SEL_W-1:0]  pair_7a_source_sel,
    output logic      [SEL_W-1:0]  pair_7b_source_sel,
    output logic      [SEL_W-1:0]  pair_8a_source_sel,
    output logic      [SEL_W-1:0]  pair_8b_source_sel
);

    // ************************************************************
    // Stored state
    // ************************************************************
    logic [REG_W-1:0]     map_a_r;
    logic [REG_W-1:0]     map_b_r;
    logic [REG_W-1:0]     map_c_r;
    logic [TAP_COUNT-1:0] custom_flag_r;
    logic                 pready_r;
    logic                 pslverr_r;
    logic [DATA_W-1:0]    prdata_r;
    logic [DATA_W-1:0]    prdata_nxt;
    logic [COEFF_W-1:0]   mem_rd_a;
    logic [COEFF_W-1:0]   mem_rd_b;

    // ************************************************************
    // APB decode
    // ************************************************************
    wire              acc_first;
    wire              acc_done;
    wire [IDX_W-1:0]  reg_idx;
    wire              addr_ok;
    wire              hit_a;
    wire              hit_b;
    wire              hit_c;
    wire              hit_coeff;
    wire              mapped;
    wire [IDX_W-1:0]  coeff_diff;
    wire [TAP_AW-1:0] coeff_off;
    wire              wr_go;

    // First access cycle loads the answer; the second completes the transfer
    assign acc_first  = psel & penable & ~pready_r;
    assign acc_done   = psel & penable & pready_r;

    assign reg_idx    = paddr[IDX_W+1:2];
    assign addr_ok    = (paddr[ADDR_W-1:IDX_W+2] == '0) && (paddr[1:0] == 2'h0);
    assign hit_a      = addr_ok && (reg_idx == MAP_A_IDX);
    assign hit_b      = addr_ok && (reg_idx == MAP_B_IDX);
    assign hit_c      = addr_ok && (reg_idx == MAP_C_IDX);
    // One contiguous window covers all six banks of twelve
    assign hit_coeff  = addr_ok && (reg_idx >= COEFF_BASE[0])
                        && (reg_idx <= COEFF_LAST_IDX);
    assign mapped     = hit_a | hit_b | hit_c | hit_coeff;

    assign coeff_diff = reg_idx - COEFF_BASE[0];
    assign coeff_off  = coeff_diff[TAP_AW-1:0];

    // Writes take effect only on the completing edge
    assign wr_go      = acc_done & pwrite & mapped;

    // ************************************************************
    // Filter-side read address
    // ************************************************************
    wire              tap_rd_ok;
    wire [IDX_W-1:0]  tap_rd_sum;
    wire [TAP_AW-1:0] tap_rd_addr;

    // No handshake: the address is taken every edge, data follows one edge later
    assign tap_rd_ok   = (tap_rd_ch < 3'(CH_N)) && (tap_rd_idx < 4'(TAPS));
    assign tap_rd_sum  = COEFF_BASE[tap_rd_ch] - COEFF_BASE[0] + IDX_W'(tap_rd_idx);
    // Out-of-range requests read entry 0 instead of running off the array
    assign tap_rd_addr = tap_rd_ok ? tap_rd_sum[TAP_AW-1:0] : '0;

    // ************************************************************
    // Coefficient memory
    // ************************************************************
    tap_mem #(
        .W     (COEFF_W),
        .DEPTH (TAP_COUNT),
        .AW    (TAP_AW)
    ) u_tap_mem (
        .clk_sys   (clk_sys),
        .wr_en     (wr_go & hit_coeff),
        .wr_addr   (coeff_off),
        .wr_data   (pwdata[COEFF_W-1:0]),
        .rd_a_addr (coeff_off),
        .rd_a_data (mem_rd_a),
        .rd_b_addr (tap_rd_addr),
        .rd_b_data (mem_rd_b)
    );

    // ************************************************************
    // Read mux
    // ************************************************************
    wire [REG_W-1:0] coeff_word;
    wire [REG_W-1:0] rd_word;

    assign coeff_word = {custom_flag_r[coeff_off], 3'h0, mem_rd_a};
    assign rd_word    = hit_a     ? map_a_r :
                        hit_b     ? map_b_r :
                        hit_c     ? map_c_r :
                        hit_coeff ? coeff_word : 16'h0000;

    // Unused bits of a read word stay zero
    assign prdata_nxt = (pwrite || !mapped) ? '0 : {16'h0000, rd_word};

    // ************************************************************
    // APB handshake
    // ************************************************************
    // Exactly one wait state: the answer stands in the second access cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= acc_first;
            pslverr_r <= acc_first & ~mapped;
        end
    end

    // Read data is captured once, then held, so it stands with pready
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata_r <= '0;
        end else if (acc_first) begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ************************************************************
    // Mapping registers
    // ************************************************************
    // Bits the host must leave at zero are masked away on write,
    // so a stray one there never reaches the routing
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            map_a_r <= MAP_RST;
        end else if (wr_go && hit_a) begin
            map_a_r <= pwdata[REG_W-1:0] & MAP_AB_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            map_b_r <= MAP_RST;
        end else if (wr_go && hit_b) begin
            map_b_r <= pwdata[REG_W-1:0] & MAP_AB_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            map_c_r <= MAP_RST;
        end else if (wr_go && hit_c) begin
            map_c_r <= pwdata[REG_W-1:0] & MAP_C_MASK;
        end
    end

    // ************************************************************
    // Custom-coefficient select flags
    // ************************************************************
    // Bit 15 is kept per register so that a readback shows what was
    // written, while the channel select is the OR over its bank
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            custom_flag_r <= '0;
        end else if (wr_go && hit_coeff) begin
            custom_flag_r[coeff_off] <= pwdata[EN_BIT];
        end
    end

    wire [CH_N-1:0] taps_sel_nxt;

    genvar g;
    generate
        for (g = 0; g < CH_N; g++) begin : g_ch
            assign taps_sel_nxt[g] = |custom_flag_r[g*TAPS +: TAPS];
        end
    endgenerate

    // ************************************************************
    // Effective routing
    // ************************************************************
    wire             en_a;
    wire             en_b;
    wire             en_c;
    wire [SEL_W-1:0] sel_5a_nxt;
    wire [SEL_W-1:0] sel_5b_nxt;
    wire [SEL_W-1:0] sel_6a_nxt;
    wire [SEL_W-1:0] sel_6b_nxt;
    wire [SEL_W-1:0] sel_7a_nxt;
    wire [SEL_W-1:0] sel_7b_nxt;
    wire [SEL_W-1:0] sel_8a_nxt;
    wire [SEL_W-1:0] sel_8b_nxt;

    assign en_a = map_a_r[EN_BIT];
    assign en_b = map_b_r[EN_BIT];
    assign en_c = map_c_r[EN_BIT];

    // A disabled register falls back to the default routing
    assign sel_6b_nxt = en_a ? map_a_r[SEL_HI_LSB +: SEL_W]  : DEF_SEL_6B;
    assign sel_5a_nxt = en_a ? map_a_r[SEL_MID_LSB +: SEL_W] : DEF_SEL_5A;
    assign sel_5b_nxt = en_a ? map_a_r[SEL_LO_LSB +: SEL_W]  : DEF_SEL_5B;
    assign sel_7a_nxt = en_b ? map_b_r[SEL_HI_LSB +: SEL_W]  : DEF_SEL_7A;
    assign sel_7b_nxt = en_b ? map_b_r[SEL_MID_LSB +: SEL_W] : DEF_SEL_7B;
    assign sel_6a_nxt = en_b ? map_b_r[SEL_LO_LSB +: SEL_W]  : DEF_SEL_6A;
    assign sel_8a_nxt = en_c ? map_c_r[SEL_MID_LSB +: SEL_W] : DEF_SEL_8A;
    assign sel_8b_nxt = en_c ? map_c_r[SEL_LO_LSB +: SEL_W]  : DEF_SEL_8B;

    // ************************************************************
    // Output registers
    // ************************************************************
    // One extra cycle of latency keeps every output on a flop
    // Pairs steered by the first mapping register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pair_6b_source_sel <= DEF_SEL_6B;
            pair_5a_source_sel <= DEF_SEL_5A;
            pair_5b_source_sel <= DEF_SEL_5B;
        end else begin
            pair_6b_source_sel <= sel_6b_nxt;
            pair_5a_source_sel <= sel_5a_nxt;
            pair_5b_source_sel <= sel_5b_nxt;
        end
    end

    // Pairs steered by the second mapping register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pair_7a_source_sel <= DEF_SEL_7A;
            pair_7b_source_sel <= DEF_SEL_7B;
            pair_6a_source_sel <= DEF_SEL_6A;
        end else begin
            pair_7a_source_sel <= sel_7a_nxt;
            pair_7b_source_sel <= sel_7b_nxt;
            pair_6a_source_sel <= sel_6a_nxt;
        end
    end

    // Pairs steered by the third mapping register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pair_8a_source_sel <= DEF_SEL_8A;
            pair_8b_source_sel <= DEF_SEL_8B;
        end else begin
            pair_8a_source_sel <= sel_8a_nxt;
            pair_8b_source_sel <= sel_8b_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            user_taps_select <= '0;
        end else begin
            user_taps_select <= taps_sel_nxt;
        end
    end

    // Filter reads are already registered inside the memory
    assign user_tap_value = mem_rd_b;

endmodule

`default_nettype wire

/* testbench/lvds_map_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module lvds_map_monitor
    import lvds_map_pkg::*;
#(
    parameter int CH_N = 6
) (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [CH_N-1:0]   user_taps_select,
    input wire logic [SEL_W-1:0]  pair_5a_source_sel,
    input wire logic [SEL_W-1:0]  pair_5b_source_sel,
    input wire logic [SEL_W-1:0]  pair_6a_source_sel,
    input wire logic [SEL_W-1:0]  pair_6b_source_sel,
    input wire logic [SEL_W-1:0]  pair_7a_source_sel,
    input wire logic [SEL_W-1:0]  pair_7b_source_sel,
    input wire logic [SEL_W-1:0]  pair_8a_source_sel,
    input wire logic [SEL_W-1:0]  pair_8b_source_sel
);
    // ****************************************************************
    // Completed writes, by target
    // ****************************************************************
    wire logic [7:0] idx;
    wire logic       wr_ok;
    wire logic       wr_a;
    wire logic       wr_b;
    wire logic       wr_c;
    wire logic       wr_k;
    assign idx   = paddr[9:2];
    assign wr_ok = psel & penable & pready & pwrite & ~pslverr;
    assign wr_a  = wr_ok & (idx == MAP_A_IDX);
    assign wr_b  = wr_ok & (idx == MAP_B_IDX);
    assign wr_c  = wr_ok & (idx == MAP_C_IDX);
    assign wr_k  = wr_ok & (idx >= 8'h5A) & (idx <= COEFF_LAST_IDX);

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ****************************************************************
    // Bus timing and outputs tied to their cause
    // ****************************************************************
    property p_one_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not one wait state");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_err_rd;
        pslverr |-> pready && (pwrite || prdata == 32'h0);
    endproperty
    a_err_rd: assert property (p_err_rd) else $error("refused access malformed");
    property p_coeff_ok;
        pready && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 && idx >= 8'h5A
            && idx <= 8'hA1 |-> !pslverr;
    endproperty
    a_coeff_ok: assert property (p_coeff_ok) else $error("coeff address refused");
    property p_map_a;
        $changed({pair_6b_source_sel, pair_5a_source_sel, pair_5b_source_sel})
            |-> $past(wr_a, 2);
    endproperty
    a_map_a: assert property (p_map_a) else $error("pairs 6b 5a 5b moved");
    property p_map_b;
        $changed({pair_7a_source_sel, pair_7b_source_sel, pair_6a_source_sel})
            |-> $past(wr_b, 2);
    endproperty
    a_map_b: assert property (p_map_b) else $error("pairs 7a 7b 6a moved");
    property p_map_c;
        $changed({pair_8a_source_sel, pair_8b_source_sel}) |-> $past(wr_c, 2);
    endproperty
    a_map_c: assert property (p_map_c) else $error("pairs 8a 8b moved");
    property p_sel;
        $changed(user_taps_select) |-> $past(wr_k, 2);
    endproperty
    a_sel: assert property (p_sel) else $error("taps select moved");
    property p_rd_mask;
        pready && !pwrite |-> prdata[31:16] == 16'h0 && prdata[14:12] == 3'h0;
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("reserved read bits set");
endmodule

bind lvds_map_and_coeff_regs lvds_map_monitor #(.CH_N(CH_N)) lvds_map_monitor_inst (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .user_taps_select(user_taps_select), .pair_5a_source_sel(pair_5a_source_sel),
    .pair_5b_source_sel(pair_5b_source_sel), .pair_6a_source_sel(pair_6a_source_sel),
    .pair_6b_source_sel(pair_6b_source_sel), .pair_7a_source_sel(pair_7a_source_sel),
    .pair_7b_source_sel(pair_7b_source_sel), .pair_8a_source_sel(pair_8a_source_sel),
    .pair_8b_source_sel(pair_8b_source_sel));

`default_nettype wire

/* testbench/lvds_map_and_coeff_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none

module lvds_map_and_coeff_regs_test
    import lvds_map_pkg::*;
;
    logic                clk_sys = 1'b0;
    logic                rst = 1'b1;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [ADDR_W-1:0]   paddr = '0;
    logic [DATA_W-1:0]   pwdata = '0;
    logic [2:0]          tap_rd_ch = '0;
    logic [3:0]          tap_rd_idx = '0;
    logic [DATA_W-1:0]   prdata;
    logic [DATA_W-1:0]   rd;
    logic                pready;
    logic                pslverr;
    logic                err;
    logic [COEFF_W-1:0]  user_tap_value;
    logic [CH_COUNT-1:0] user_taps_select;
    logic [SEL_W-1:0]    sel [8];
    logic [15:0]         mreg [3] = '{default: 16'h0};
    logic [12:0]         cf [TAP_COUNT] = '{default: 13'h0};
    logic [3:0]          dflt [8] = '{DEF_SEL_5A, DEF_SEL_5B, DEF_SEL_6A, DEF_SEL_6B,
                                      DEF_SEL_7A, DEF_SEL_7B, DEF_SEL_8A, DEF_SEL_8B};
    int                  rs [8] = '{0, 0, 1, 0, 1, 1, 2, 2};
    int                  rl [8] = '{4, 0, 0, 8, 8, 4, 4, 0};
    logic [7:0]          bad [5] = '{8'h52, 8'h56, 8'h59, 8'hA2, 8'hFF};
    int                  errors = 0;
    int                  total_checks = 0;
    int                  seed = 63;
    int                  i;
    int                  k;

    always #2.5 clk_sys = ~clk_sys;

    lvds_map_and_coeff_regs lvds_map_and_coeff_regs_inst (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tap_rd_ch(tap_rd_ch), .tap_rd_idx(tap_rd_idx),
        .user_tap_value(user_tap_value), .user_taps_select(user_taps_select),
        .pair_5a_source_sel(sel[0]), .pair_5b_source_sel(sel[1]),
        .pair_6a_source_sel(sel[2]), .pair_6b_source_sel(sel[3]),
        .pair_7a_source_sel(sel[4]), .pair_7b_source_sel(sel[5]),
        .pair_8a_source_sel(sel[6]), .pair_8b_source_sel(sel[7]));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // Waits for pready under a bound; a hang ends the run
    task automatic apb(input logic w, input logic [7:0] ix, input logic [15:0] d,
                       input logic [1:0] lo);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, ix, lo};
        pwdata <= {16'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        if (n == 16) begin
            errors++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [3:0] exp_sel(input int p);
        return mreg[rs[p]][15] ? mreg[rs[p]][rl[p]+:4] : dflt[p];
    endfunction

    function automatic logic [CH_COUNT-1:0] exp_taps();
        logic [CH_COUNT-1:0] s = '0;
        for (int c = 0; c < TAP_COUNT; c++)
            if (cf[c][12] === 1'b1)
                s[c/12] = 1'b1;
        return s;
    endfunction

    task automatic check_maps();
        for (int p = 0; p < 8; p++)
            chk("pair_sel", sel[p], exp_sel(p));
    endtask

    // Flag and value packed as the register wants them, reserved bits zero
    task automatic wr_coef(input int c);
        apb(1'b1, 8'h5A + 8'(c), {cf[c][12], 3'b000, cf[c][11:0]}, 2'b00);
        chk("coeff_err", err, 0);
        repeat (2) @(posedge clk_sys);
        chk("taps_sel", user_taps_select, exp_taps());
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        check_maps();
        chk("taps_sel", user_taps_select, 0);
        for (k = 0; k < 12; k++) begin
            for (i = 0; i < 3; i++) begin
                mreg[i] = $random(seed) & (i == 2 ? MAP_C_MASK : MAP_AB_MASK);
                if (k < 2)
                    mreg[i][15] = k[0];
                apb(1'b1, MAP_A_IDX + 8'(i), mreg[i], 2'b00);
                repeat (2) @(posedge clk_sys);
                check_maps();
                apb(1'b0, MAP_A_IDX + 8'(i), 16'h0, 2'b00);
                chk("map_rd", rd, mreg[i]);
            end
        end
        for (k = 0; k < TAP_COUNT; k++) begin
            cf[k] = $random(seed);
            wr_coef(k);
        end
        for (k = 0; k < TAP_COUNT; k++) begin
            apb(1'b0, 8'h5A + 8'(k), 16'h0, 2'b00);
            chk("coeff_rd", rd, {cf[k][12], 3'b000, cf[k][11:0]});
            tap_rd_ch <= 3'(k / 12);
            tap_rd_idx <= 4'(k % 12);
            repeat (2) @(posedge clk_sys);
            chk("tap_val", user_tap_value, cf[k][11:0]);
        end
        // Clearing one flag must leave the channel custom while any other is set
        for (k = 0; k < TAP_COUNT; k++) begin
            cf[k][12] = 1'b0;
            wr_coef(k);
        end
        for (k = 0; k < 5; k++) begin
            apb(k[0], bad[k], 16'h8FFF, 2'b00);
            chk("bad_err", err, 1);
            if (!k[0])
                chk("bad_rd", rd, 0);
        end
        apb(1'b1, MAP_A_IDX, 16'h8123, 2'b01);
        chk("mis_err", err, 1);
        repeat (2) @(posedge clk_sys);
        check_maps();
        // Reset in mid-run: flags and routing drop back, stored values stay
        cf[0][12] = 1'b1;
        wr_coef(0);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        mreg = '{default: 16'h0};
        cf[0][12] = 1'b0;
        @(posedge clk_sys);
        check_maps();
        chk("taps_sel", user_taps_select, exp_taps());
        apb(1'b0, 8'h5A, 16'h0, 2'b00);
        chk("coeff_rd", rd, {cf[0][12], 3'b000, cf[0][11:0]});
        test_done();
    end
endmodule

`default_nettype wire
